// ==== logic/mrat_map.svh ====
// constants for the memory request arbiter and tagger
// assumes a single 100 MHz clock; included by the top module
// Overview of operation
// - central address held relative, absolute adds base
// - window is base to base plus length minus one
// - relative not below length blocks central priority
// - central grant needs request, no hopper, ordering
// - peripheral grant only when nothing higher granted
// - peripheral reads give addresses; exchange auto-advances
// - swap counter steps sixteen locations per exchange
// - entry stage loads six-bit tag with address
// - tag bit five marks stores
// - tag bit four marks exchanges only
// - tag bit three central, operand during exchange
// - tag bits zero to two carry register
// - tags 00,10,11-15,40 peripheral/fetch/read/write
// - tag 50 jump store, 56/57 operand stores
// - exchange tags 60-77 control/addr, operand regs
// - only legal tags decoded, others alias
// - started reference decodes tag to gate data
// - 16 or 32 banks, four per chassis
// - low address bits select bank and chassis
// - idle bank gives accept and go pulse
// - remaining twelve bits select word in bank
// - busy bank blocks cycle, retry every 300 ns
// - entry priority hopper, central, then peripheral
// - hopper grant on third stage full, no accept
`ifndef MRAT_MAP_SVH
`define MRAT_MAP_SVH
`define MRAT_CLK_NS          10
`define MRAT_RETRY_NS        300
`define MRAT_QUEUE_STAGES    3
`define MRAT_STAGE_CYC       (`MRAT_RETRY_NS / (`MRAT_QUEUE_STAGES * `MRAT_CLK_NS))
`define MRAT_SWAP_WORDS      5'h10
`define MRAT_BANK_CYC_DEF    100
`define MRAT_TAG_WRITE       5
`define MRAT_TAG_SWAP        4
`define MRAT_TAG_CENTRAL     3
`define MRAT_TAG_PERIPH_RD   6'h00
`define MRAT_TAG_FETCH       6'h08
`define MRAT_TAG_PERIPH_WR   6'h20
`define MRAT_TAG_JUMP_STORE  6'h28
`define MRAT_TAG_SWAP_BASE   6'h30
`define MRAT_WORD_LSB        5
`define MRAT_WORD_LSB_SMALL  4
`endif

// ==== logic/mrat_pkg.sv ====
// types for the memory request arbiter and tagger
// assumes mrat_map.svh supplies the numeric constants
package mrat_pkg;
    // central reference kinds presented with the relative address
    typedef enum logic [1:0] {
        MRAT_CP_FETCH = 2'h0,
        MRAT_CP_READ  = 2'h1,
        MRAT_CP_WRITE = 2'h2,
        MRAT_CP_JUMP  = 2'h3
    } mrat_cp_kind_e;
    // hopper stage contents
    typedef struct packed {
        logic        full;
        logic [17:0] addr;
        logic [5:0]  tag;
    } mrat_stage_s;
endpackage

// ==== logic/mrat_bank_busy.sv ====
// busy timers for the interleaved banks: one down counter per bank
// assumes go pulses arrive only for idle banks
`timescale 1ns/1ps
module mrat_bank_busy
    import mrat_pkg::*;
#(
    parameter int NBANK = 32,
    parameter int CYC   = 100
)(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // start and state
    input  wire logic [NBANK-1:0] go,
    output logic      [NBANK-1:0] busy
);
    genvar b;
    // each bank holds busy for its whole cycle time
    generate
        for (b = 0; b < NBANK; b++)
        begin : g_bank
            logic [7:0] cnt_reg;
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                    cnt_reg <= 8'h00;
                else if (go[b])
                    cnt_reg <= 8'(CYC);
                else if (cnt_reg != 8'h00)
                    cnt_reg <= cnt_reg - 8'h01;
            end
            assign busy[b] = (cnt_reg != 8'h00);
        end
    endgenerate
endmodule // mrat_bank_busy

// ==== logic/mrat_top.sv ====
// memory request arbiter, tagger and bank selector with recirculating queue
// assumes requesters hold requests until taken; peripheral pulses are pins and resynchronised
`timescale 1ns/1ps
`include "mrat_map.svh"
module mrat_top
    import mrat_pkg::*;
#(
    parameter int BANK_CYC = `MRAT_BANK_CYC_DEF,
    parameter bit BIG_MEM  = 1'b1
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // region window set at exchange time
    input  wire logic        region_load,
    input  wire logic [17:0] region_base_in,
    input  wire logic [17:0] region_length_in,
    // central request
    input  wire logic        cp_req,
    input  wire logic [17:0] cp_rel_addr,
    input  wire logic [1:0]  cp_kind,
    input  wire logic [2:0]  cp_reg,
    // peripheral request pins
    input  wire logic [17:0] peripheral_address_in,
    input  wire logic        pp_read,
    input  wire logic        pp_write,
    input  wire logic        pp_swap,
    // grant and status flags toward the requesters
    output logic             cp_taken,
    output logic             cp_bounds_err,
    output logic             pp_taken,
    output logic             swap_busy,
    // memory side
    output logic             accept,
    output logic [31:0]      bank_go,
    output logic [4:0]       bank_sel,
    output logic [11:0]      word_sel,
    output logic [17:0]      mem_abs_addr,
    output logic [5:0]       gate_tag,
    output logic             gate_write,
    output logic             gate_swap,
    output logic             gate_cpu,
    output logic [2:0]       gate_reg
);
    localparam int NBANK = 32;
    localparam int SCYC  = `MRAT_STAGE_CYC;

    // peripheral pins pass two flops
    logic [2:0]  pp_s1_reg;
    logic [2:0]  pp_s2_reg;
    logic [2:0]  pp_s3_reg;           // edge reference, cleared in reset; a pin held high through reset gives an edge once reset ends
    logic [17:0] ppa_s1_reg;
    logic [17:0] ppa_s2_reg;
    always_ff @(posedge sys_clk)
    begin
        pp_s1_reg  <= {pp_swap, pp_write, pp_read};
        pp_s2_reg  <= pp_s1_reg;
        pp_s3_reg  <= rst_n ? pp_s2_reg : 3'h0;
        ppa_s1_reg <= peripheral_address_in;
        ppa_s2_reg <= ppa_s1_reg;
    end
    // pulse edges form the peripheral request
    wire [2:0] pp_edge = pp_s2_reg & ~pp_s3_reg;

    // registers
    logic [17:0] region_base_reg;
    logic [17:0] region_length_reg;
    logic [17:0] relative_address_hold;
    logic [1:0]  hold_kind_reg;
    logic [2:0]  hold_reg_reg;
    logic        hold_full_reg;
    logic [17:0] pp_addr_reg;
    logic [1:0]  pp_kind_reg;         // 0 read, 1 write, 2 swap
    logic        pp_pend_reg;
    logic [4:0]  swap_address_counter;
    mrat_stage_s queue_entry_stage;
    mrat_stage_s queue_third_stage;
    mrat_stage_s queue_return_stage;
    logic        third_full_dly_reg;  // third stage full seen one step late, in step with the return stage
    logic        entry_acc_reg;       // accept flags ride along with their address
    logic        third_acc_reg;
    logic        return_acc_reg;
    logic [7:0]  stage_cnt_reg;
    logic        step;
    logic [NBANK-1:0] busy;

    // stage enable: three stages share the 300 ns retry round trip evenly;
    // the spacing inside the trip is coarser than a four-register hopper but unseen outside
    assign step = (stage_cnt_reg == 8'(SCYC - 1));

    // writes and central reads waiting in the queue
    // accepted entries still count until they leave; conservative, never out of order
    function automatic logic is_wr(input mrat_stage_s s);
        is_wr = s.full & s.tag[`MRAT_TAG_WRITE];
    endfunction
    function automatic logic is_cprd(input mrat_stage_s s);
        is_cprd = s.full & s.tag[`MRAT_TAG_CENTRAL] & ~s.tag[`MRAT_TAG_WRITE]
                  & ~s.tag[`MRAT_TAG_SWAP];
    endfunction
    wire wr_in_q   = is_wr(queue_entry_stage) | is_wr(queue_third_stage)
                     | is_wr(queue_return_stage);
    wire cprd_in_q = is_cprd(queue_entry_stage) | is_cprd(queue_third_stage)
                     | is_cprd(queue_return_stage);

    // priority network
    wire cp_is_wr   = hold_kind_reg[1];
    wire in_bounds  = relative_address_hold < region_length_reg;
    wire order_ok   = cp_is_wr ? ~cprd_in_q : ~wr_in_q;
    wire hop_grant  = third_full_dly_reg & ~return_acc_reg;
    wire cp_grant   = step & hold_full_reg & ~hop_grant & in_bounds & order_ok;
    wire pp_grant   = step & pp_pend_reg & ~hop_grant & ~cp_grant;
    wire cp_bad     = hold_full_reg & ~in_bounds;
    wire swap_last  = (swap_address_counter == 5'(`MRAT_SWAP_WORDS - 1));

    // tag builder for central references
    wire [5:0] cp_tag =
        (hold_kind_reg == MRAT_CP_FETCH) ? `MRAT_TAG_FETCH :
        (hold_kind_reg == MRAT_CP_READ)  ? {3'h1, hold_reg_reg} :
        (hold_kind_reg == MRAT_CP_JUMP)  ? `MRAT_TAG_JUMP_STORE :
                                           {3'h5, hold_reg_reg};
    // peripheral and swap tags; swap word n pairs control/address regs then operands
    wire [5:0] pp_tag =
        (pp_kind_reg == 2'h0) ? `MRAT_TAG_PERIPH_RD :
        (pp_kind_reg == 2'h1) ? `MRAT_TAG_PERIPH_WR :
        (`MRAT_TAG_SWAP_BASE | {2'h0, swap_address_counter[3:0]});
    wire [17:0] cp_abs = region_base_reg + relative_address_hold;
    wire [17:0] pp_abs = pp_addr_reg + {13'h0, swap_address_counter};

    // new entry stage contents, hopper first
    mrat_stage_s entry_next;
    assign entry_next =
        hop_grant ? queue_return_stage :
        cp_grant  ? '{full: 1'b1, addr: cp_abs, tag: cp_tag} :
        pp_grant  ? '{full: 1'b1, addr: pp_abs, tag: pp_tag} :
                    '{full: 1'b0, addr: 18'h0, tag: 6'h0};

    // bank decode on the entry stage
    wire [4:0] bsel  = BIG_MEM ? queue_entry_stage.addr[4:0]
                               : {1'b0, queue_entry_stage.addr[3:0]};
    // the address goes to the banks once per pass, in the first cycle after entry;
    // a busy bank is not waited on here, the address comes back after a round trip
    wire       issue = (stage_cnt_reg == 8'h00);
    wire       hit   = issue & queue_entry_stage.full & ~entry_acc_reg
                       & ~busy[bsel];
    // word inside the bank: the bits above the bank select, 17-bit or 16-bit address
    wire [11:0] wsel = BIG_MEM ? queue_entry_stage.addr[`MRAT_WORD_LSB +: 12]
                               : queue_entry_stage.addr[`MRAT_WORD_LSB_SMALL +: 12];
    wire [NBANK-1:0] go_vec = hit ? (32'h1 << bsel) : 32'h0;

    // stage timer and window registers
    // the window is expected to change only between programs; no guard against a live load
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            stage_cnt_reg     <= 8'h00;
            region_base_reg   <= 18'h0;
            region_length_reg <= 18'h0;
        end
        else
        begin
            stage_cnt_reg <= step ? 8'h00 : stage_cnt_reg + 8'h01;
            if (region_load)
            begin
                region_base_reg   <= region_base_in;
                region_length_reg <= region_length_in;
            end
        end
    end

    // central holding register, only taken when empty
    // a request seen while the holder is full is not latched; the source keeps it up
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            hold_full_reg <= 1'b0;
        else if (cp_grant)
            hold_full_reg <= 1'b0;
        else if (cp_req & ~hold_full_reg)
            hold_full_reg <= 1'b1;
        if (cp_req & ~hold_full_reg)
        begin
            relative_address_hold <= cp_rel_addr;
            hold_kind_reg         <= cp_kind;
            hold_reg_reg          <= cp_reg;
        end
    end

    // peripheral request and swap address counter
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pp_pend_reg          <= 1'b0;
            pp_kind_reg          <= 2'h0;
            swap_address_counter <= 5'h00;
            pp_addr_reg          <= 18'h0;
        end
        else if (pp_grant)
        begin
            if (pp_kind_reg == 2'h2 && !swap_last)
                swap_address_counter <= swap_address_counter + 5'h01;
            else
            begin
                pp_pend_reg          <= 1'b0;
                swap_address_counter <= 5'h00;
            end
        end
        else if (!pp_pend_reg && pp_edge != 3'h0)
        begin
            pp_pend_reg <= 1'b1;
            pp_addr_reg <= ppa_s2_reg;
            pp_kind_reg <= pp_edge[2] ? 2'h2 : (pp_edge[1] ? 2'h1 : 2'h0);
        end
    end

    // recirculating queue: entry -> third -> return -> entry on retry
    // accept flags travel with their stage, or an accepted word would come back
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            queue_entry_stage  <= '0;
            queue_third_stage  <= '0;
            queue_return_stage <= '0;
            entry_acc_reg      <= 1'b0;
            third_acc_reg      <= 1'b0;
            return_acc_reg     <= 1'b0;
            third_full_dly_reg <= 1'b0;
        end
        else if (step)
        begin
            queue_entry_stage  <= entry_next;
            queue_third_stage  <= queue_entry_stage;
            queue_return_stage <= queue_third_stage;
            entry_acc_reg      <= 1'b0;
            third_acc_reg      <= entry_acc_reg | hit;
            return_acc_reg     <= third_acc_reg;
            third_full_dly_reg <= queue_third_stage.full;
        end
        else if (hit)
            entry_acc_reg <= 1'b1;
    end

    // memory side outputs: accept, go and the address split
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            accept       <= 1'b0;
            bank_go      <= 32'h0;
            bank_sel     <= 5'h0;
            word_sel     <= 12'h0;
            mem_abs_addr <= 18'h0;
        end
        else
        begin
            accept       <= hit;
            bank_go      <= go_vec;
            bank_sel     <= bsel;
            word_sel     <= wsel;
            mem_abs_addr <= queue_entry_stage.addr;
        end
    end

    // decoded gating; only an accepted reference may move data, so all is qualified by hit
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            gate_tag   <= 6'h0;
            gate_write <= 1'b0;
            gate_swap  <= 1'b0;
            gate_cpu   <= 1'b0;
            gate_reg   <= 3'h0;
        end
        else
        begin
            gate_tag   <= hit ? queue_entry_stage.tag : 6'h0;
            gate_write <= hit & queue_entry_stage.tag[`MRAT_TAG_WRITE];
            gate_swap  <= hit & queue_entry_stage.tag[`MRAT_TAG_SWAP];
            gate_cpu   <= hit & queue_entry_stage.tag[`MRAT_TAG_CENTRAL];
            gate_reg   <= hit ? queue_entry_stage.tag[2:0] : 3'h0;
        end
    end

    // grant and status flags toward the requesters
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cp_taken      <= 1'b0;
            pp_taken      <= 1'b0;
            cp_bounds_err <= 1'b0;
            swap_busy     <= 1'b0;
        end
        else
        begin
            cp_taken      <= cp_grant;
            pp_taken      <= pp_grant;
            cp_bounds_err <= cp_bad;
            swap_busy     <= pp_pend_reg & (pp_kind_reg == 2'h2);
        end
    end

    // bank busy timers
    mrat_bank_busy #(.NBANK(NBANK), .CYC(BANK_CYC)) u_busy (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .go      (go_vec),
        .busy    (busy)
    );
endmodule // mrat_top

// ==== bench/mrat_checker.sv ====
// concurrent checks on the arbiter's memory-side outputs and grant flags
// assumes bind onto mrat_top with the 32-bank memory and a short bank cycle
`timescale 1ns/1ps
module mrat_checker #(
    parameter int BANK_CYC = 10
)(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // grants
    input wire logic        cp_taken,
    input wire logic        cp_bounds_err,
    input wire logic        pp_taken,
    // memory side
    input wire logic        accept,
    input wire logic [31:0] bank_go,
    input wire logic [4:0]  bank_sel,
    input wire logic [11:0] word_sel,
    input wire logic [17:0] mem_abs_addr,
    input wire logic [5:0]  gate_tag,
    input wire logic        gate_write,
    input wire logic        gate_swap,
    input wire logic        gate_cpu,
    input wire logic [2:0]  gate_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] held_go;
    // remember the bank last started; the banks run ten cycles so eight is safe
    always_ff @(posedge sys_clk)
    begin
        if (accept)
            held_go <= bank_go;
    end
    sequence s_start;
        accept ##1 1'b1;
    endsequence
    AST_BUSY: assert property (s_start |-> ((bank_go & held_go) == 32'h0)[*8])
        else $error("busy bank started again");
    AST_GO: assert property (accept |-> bank_go == (32'h00000001 << bank_sel))
        else $error("go not one-hot on selected bank");
    AST_IDLE: assert property (!accept |-> bank_go == 32'h0 && gate_tag == 6'h00)
        else $error("go or gating without accept");
    AST_BANK: assert property (accept |-> bank_sel == mem_abs_addr[4:0])
        else $error("bank select wrong");
    AST_WORD: assert property (accept |-> word_sel == mem_abs_addr[16:5])
        else $error("word select wrong");
    AST_WRITE: assert property (accept |-> gate_write == gate_tag[5])
        else $error("write gate differs from tag");
    AST_SWAP: assert property (accept |-> gate_swap == gate_tag[4])
        else $error("swap gate differs from tag");
    AST_REG: assert property (accept |-> {gate_cpu, gate_reg} == gate_tag[3:0]
        && (!gate_cpu || gate_swap || (gate_write ? gate_reg inside {3'h0, 3'h6, 3'h7}
        : gate_reg <= 3'h5)))
        else $error("register gate differs from tag");
    AST_LEGAL: assert property (accept |-> gate_tag inside {6'h00, [6'h08:6'h0D], 6'h20,
        6'h28, 6'h2E, 6'h2F, [6'h30:6'h3F]})
        else $error("illegal tag issued");
    AST_PRIO: assert property (cp_taken |-> !pp_taken)
        else $error("two sources granted together");
    AST_BOUNDS: assert property ($rose(cp_bounds_err) |-> (!cp_taken)[*3])
        else $error("out of bounds reference granted");
endmodule // mrat_checker

bind mrat_top mrat_checker #(.BANK_CYC(BANK_CYC)) mrat_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .cp_taken(cp_taken), .cp_bounds_err(cp_bounds_err),
    .pp_taken(pp_taken), .accept(accept), .bank_go(bank_go), .bank_sel(bank_sel),
    .word_sel(word_sel), .mem_abs_addr(mem_abs_addr), .gate_tag(gate_tag),
    .gate_write(gate_write), .gate_swap(gate_swap), .gate_cpu(gate_cpu), .gate_reg(gate_reg)
);

// ==== bench/mrat_pp_model.sv ====
// peripheral processor model: one address with at most one of three pulses (op 3 gives none)
// assumes the bench spaces its requests; the design resynchronises the pins
`timescale 1ns/1ps
module mrat_pp_model (
    // requests from the bench
    input  wire logic        sys_clk,
    input  wire logic        start,
    input  wire logic [1:0]  op,
    input  wire logic [17:0] addr,
    // pins toward the design
    output logic      [17:0] peripheral_address_in,
    output logic             pp_read,
    output logic             pp_write,
    output logic             pp_swap
);
    int          cnt = 0;
    logic [1:0]  op_reg = 2'h0;
    logic [17:0] last = 18'h00000;
    // pulse stands four cycles, address forty, long enough to span sync and a step
    always @(posedge sys_clk)
    begin
        if (start)
        begin
            cnt <= 40;
            op_reg <= op;
            last <= addr;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // a released address line shows the inverse so stale values are not trusted
    assign peripheral_address_in = (cnt > 0) ? last : ~last;
    assign pp_read  = (cnt > 36) && (op_reg == 2'h0);
    assign pp_write = (cnt > 36) && (op_reg == 2'h1);
    assign pp_swap  = (cnt > 36) && (op_reg == 2'h2);
endmodule // mrat_pp_model

// ==== bench/tb_mrat_top.sv ====
// self-checking bench for mrat_top: central, peripheral, exchange, busy and bounds
// assumes 100 MHz clock, short bank cycle and a peripheral model on the pins
`timescale 1ns/1ps
module tb_mrat_top;
    import mrat_pkg::*;
    localparam int BCYC = 10;
    localparam int SCYC = 10;     // 300 ns round trip over three stages at 10 ns
    logic sys_clk = 1'b0, rst_n = 1'b0, region_load = 1'b0, cp_req = 1'b0, pp_start = 1'b0;
    logic [17:0] base = 18'h00000, len = 18'h00000, cp_rel_addr = 18'h00000, pp_addr = 18'h00000;
    logic [1:0] cp_kind = 2'h0, pp_op = 2'h0;
    logic [2:0] cp_reg = 3'h0;
    logic [17:0] ppa, mem_abs_addr;
    logic ppr, ppw, pps, cp_taken, cp_bounds_err, pp_taken, swap_busy, accept;
    logic gate_write, gate_swap, gate_cpu;
    logic [31:0] bank_go;
    logic [4:0] bank_sel;
    logic [11:0] word_sel;
    logic [5:0] gate_tag;
    logic [2:0] gate_reg;
    int error_cnt = 0, num_checks = 0, cyc = 0, w = 0, seed = 32'h8d95947d;
    logic [17:0] a;
    logic hit;

    mrat_top #(.BANK_CYC(BCYC)) mrat_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .region_load(region_load), .region_base_in(base), .region_length_in(len),
        .cp_req(cp_req), .cp_rel_addr(cp_rel_addr), .cp_kind(cp_kind), .cp_reg(cp_reg),
        .peripheral_address_in(ppa), .pp_read(ppr), .pp_write(ppw), .pp_swap(pps),
        .cp_taken(cp_taken), .cp_bounds_err(cp_bounds_err), .pp_taken(pp_taken),
        .swap_busy(swap_busy), .accept(accept), .bank_go(bank_go), .bank_sel(bank_sel),
        .word_sel(word_sel), .mem_abs_addr(mem_abs_addr), .gate_tag(gate_tag),
        .gate_write(gate_write), .gate_swap(gate_swap), .gate_cpu(gate_cpu), .gate_reg(gate_reg));
    mrat_pp_model mrat_pp_model_inst (.sys_clk(sys_clk), .start(pp_start), .op(pp_op),
        .addr(pp_addr), .peripheral_address_in(ppa), .pp_read(ppr), .pp_write(ppw),
        .pp_swap(pps));

    // clock and a cycle ceiling so a hang still ends in the report
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs move one nanosecond after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_acc(output int n);
        n = 0;
        while (accept !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        chk("accept", accept, 1'b1);
    endtask
    function automatic logic [5:0] exp_tag(input logic [1:0] k, input logic [2:0] r);
        case (k)
            2'h0: exp_tag = 6'h08;
            2'h1: exp_tag = {3'h1, r};
            2'h2: exp_tag = {3'h5, r};
            default: exp_tag = 6'h28;
        endcase
    endfunction
    // request is raised for one cycle only, the holding register takes it at once
    task automatic cp_ref(input logic [1:0] k, input logic [2:0] r, input logic [17:0] rel);
        cp_req = 1'b1;
        cp_kind = k;
        cp_reg = r;
        cp_rel_addr = rel;
        tick(1);
        cp_req = 1'b0;
        wait_acc(w);
        chk("cp tag", gate_tag, exp_tag(k, r));
        chk("abs addr", mem_abs_addr, base + rel);
        tick(1);
    endtask
    task automatic pp_ref(input logic [1:0] op, input logic [17:0] ad, input logic [5:0] tg);
        pp_op = op;
        pp_addr = ad;
        pp_start = 1'b1;
        tick(1);
        pp_start = 1'b0;
        wait_acc(w);
        chk("pp tag", gate_tag, tg);
        chk("pp addr", mem_abs_addr, ad);
        tick(50);
    endtask

    initial
    begin
        tick(6);
        rst_n = 1'b1;
        base = {4'h0, 14'($random(seed))};
        len = 18'h00800;
        region_load = 1'b1;
        tick(1);
        region_load = 1'b0;
        cp_ref(2'h1, 3'h1, len - 18'h1);
        for (int i = 0; i < 12; i++)
        begin
            cp_ref(2'(i), (i % 4 == 2) ? 3'h6 + 3'(i % 8 / 4) : 3'h1 + 3'(i % 5),
                18'($unsigned($random(seed))) % len);
        end
        $display("test central done");
        cp_ref(2'h1, 3'h2, 18'h00040);
        cp_ref(2'h1, 3'h3, 18'h00060);
        // refused once by the busy bank, taken on the next step and back one round trip later
        chk("retry gap", w, 4 * SCYC - 2);
        $display("test busy done");
        pp_ref(2'h0, 18'($random(seed)), 6'h00);
        pp_ref(2'h1, 18'($random(seed)), 6'h20);
        $display("test peripheral done");
        a = 18'($random(seed)) & 18'h1FFF0;
        pp_op = 2'h2;
        pp_addr = a;
        pp_start = 1'b1;
        tick(1);
        pp_start = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            wait_acc(w);
            chk("swap addr", mem_abs_addr, a + 18'(i));
            chk("swap tag", gate_tag, 6'h30 + 6'(i));
            tick(1);
        end
        tick(40);
        chk("swap end", {swap_busy, accept}, 2'h0);
        $display("test exchange done");
        pp_op = 2'h0;
        pp_addr = 18'h00101;
        pp_start = 1'b1;
        cp_req = 1'b1;
        cp_kind = 2'h0;
        cp_rel_addr = 18'h00002;
        tick(1);
        pp_start = 1'b0;
        cp_req = 1'b0;
        wait_acc(w);
        chk("first source", gate_tag, 6'h08);
        tick(1);
        wait_acc(w);
        chk("second source", gate_tag, 6'h00);
        tick(50);
        $display("test priority done");
        hit = 1'b0;
        cp_req = 1'b1;
        cp_rel_addr = len;
        tick(1);
        cp_req = 1'b0;
        repeat (40)
        begin
            tick(1);
            hit = hit | cp_taken | accept;
        end
        chk("bounds flag", cp_bounds_err, 1);
        chk("bounds grant", hit, 0);
        $display("test bounds done");
        results();
    end
endmodule // tb_mrat_top
